// ---- rtl/pfd_defs.vh ----
// Shared constants for the packet buffer, serializer and pattern detector.
// Assumes inclusion by bare name from files under rtl/.
`ifndef PFD_DEFS_VH
`define PFD_DEFS_VH
`define PFD_DEPTH 64
`define PFD_PTR_W 6
`define PFD_CNT_W 7
`define PFD_BYTE_W 8
`define PFD_PAT_W 64
`define PFD_LEN_W 3
`define PFD_MODE_W 3
`define PFD_MODE_SLEEP 3'h0
`define PFD_MODE_STBY 3'h1
`define PFD_MODE_TX 3'h3
`define PFD_MODE_RX 3'h5
`define PFD_BIT_MSB 3'h7
`define PFD_BIT_LSB 3'h0
`define PFD_CNT_ZERO 7'h00
`define PFD_CNT_ONE 7'h01
`endif

// ---- rtl/pfd_sync2.v ----
// Two flip-flop level synchroniser.
// Assumes d comes from outside the clk_sys domain.
`timescale 1ns/1ns
module pfd_sync2
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Level in and out
  input wire d,
  output reg q
);
  reg meta_ff;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // pfd_sync2

// ---- rtl/pfd_pattern_det.v ----
// Pattern detector: shifts received bits and compares with the programmed pattern.
// Assumes bit_valid is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/1ns
`include "pfd_defs.vh"
module pfd_pattern_det
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Configuration
  input wire enable,
  input wire [`PFD_LEN_W-1:0] pattern_length,
  input wire [`PFD_PAT_W-1:0] pattern_value,
  // Bit stream and clears
  input wire bit_valid,
  input wire bit_in,
  input wire clear,
  // Result
  output reg pattern_match_flag
);
  reg [`PFD_PAT_W-1:0] shift_ff;
  reg [`PFD_PAT_W-1:0] nxt_shift;
  reg [`PFD_PAT_W-1:0] mask;
  reg [`PFD_PAT_W-1:0] target;
  integer i;

  // Pattern sits left-aligned: first received bit meets bit 7 of byte one
  always @*
  begin
    nxt_shift = {shift_ff[`PFD_PAT_W-2:0], bit_in};
    mask = {`PFD_PAT_W{1'b0}};
    for (i = 0; i < `PFD_PAT_W; i = i + 1)
      if (i < ((pattern_length + 1) * `PFD_BYTE_W))
        mask[i] = 1'b1;
    target = pattern_value >> ((`PFD_LEN_W'd7 - pattern_length) * `PFD_BYTE_W);
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff <= {`PFD_PAT_W{1'b0}};
      pattern_match_flag <= 1'b0;
    end
    else
    begin
      if (bit_valid && enable)
        shift_ff <= nxt_shift;
      if (bit_valid && enable && ((nxt_shift & mask) == (target & mask)))
        pattern_match_flag <= 1'b1;
      else if (clear)
        pattern_match_flag <= 1'b0;
    end
  end
endmodule // pfd_pattern_det

// ---- rtl/pfd_fifo_core.v ----
// Top: packet buffer, serializer and pattern detector on clk_sys.
// Assumes host strobes are clk_sys pulses; chip select and link clock are async pins.
`timescale 1ns/1ns
`include "pfd_defs.vh"
module pfd_fifo_core
#(
  parameter DEPTH = `PFD_DEPTH,
  parameter PTR_W = `PFD_PTR_W,
  parameter CNT_W = `PFD_CNT_W
)
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Mode control
  input wire [`PFD_MODE_W-1:0] op_mode,
  input wire continuous_mode,
  input wire mode_settled,
  input wire [`PFD_LEN_W-1:0] frame_len_bytes,
  // Host buffer access
  input wire spi_cs_n,
  input wire host_wr,
  input wire [`PFD_BYTE_W-1:0] host_wdata,
  input wire host_rd,
  output reg [`PFD_BYTE_W-1:0] host_rdata,
  input wire overflow_clr,
  // Configuration
  input wire [CNT_W-2:0] fill_threshold,
  input wire pattern_detect_enable,
  input wire [`PFD_LEN_W-1:0] pattern_length,
  input wire [`PFD_PAT_W-1:0] pattern_value,
  // Modem link
  input wire link_clk,
  input wire rx_bit,
  output reg tx_bit,
  // Status
  output reg fifo_none_left,
  output reg fifo_no_room,
  output reg fifo_overflow_flag,
  output reg fill_level_flag,
  output reg frame_sent,
  output wire pattern_match_flag
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_SHIFT = 3'b100;

  reg [`PFD_BYTE_W-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_ff;
  reg [PTR_W-1:0] rd_ptr_ff;
  reg [CNT_W-1:0] count_ff;
  reg [CNT_W-1:0] nxt_count;
  reg [`PFD_MODE_W-1:0] mode_ff;
  reg cs_d_ff;
  reg lclk_d_ff;
  reg level_hold_ff;
  reg [2:0] state_ff;
  reg [`PFD_BYTE_W-1:0] ser_ff;
  reg [2:0] bit_cnt_ff;
  reg [2:0] byte_left_ff;
  reg rx_collect_ff;
  reg empty_d_ff;
  wire cs_s;
  wire lclk_s;
  wire rx_s;
  wire cs_on_s;
  wire lclk_low_s;
  wire empty_rise;
  wire lclk_rise;
  wire lclk_fall;
  wire cs_fall;
  wire in_rx;
  wire in_tx;
  wire was_tx;
  wire was_rx;
  wire was_low;
  wire mode_clear;
  wire buf_clear;
  wire ser_wr;
  wire ser_rd;
  wire do_wr;
  wire do_rd;
  wire wr_req;
  wire active;

  // Host sees buffer only once the mode has settled, and never in continuous operation
  assign active = !continuous_mode && mode_settled;

  // Synchronisers clear to 0, so idle-high pins enter inverted: no false edge after reset
  pfd_sync2 u_sync_cs
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(!spi_cs_n),
    .q(cs_on_s)
  );

  pfd_sync2 u_sync_lclk
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(!link_clk),
    .q(lclk_low_s)
  );

  pfd_sync2 u_sync_rx
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(rx_bit),
    .q(rx_s)
  );

  assign cs_s = !cs_on_s;
  assign lclk_s = !lclk_low_s;
  // Receive samples on link rises, transmit moves on link falls
  assign lclk_rise = lclk_s && !lclk_d_ff;
  assign lclk_fall = !lclk_s && lclk_d_ff;
  assign cs_fall = !cs_s && cs_d_ff;

  // Codes other than the four named modes count as other modes
  assign in_rx = (op_mode == `PFD_MODE_RX);
  assign in_tx = (op_mode == `PFD_MODE_TX);
  assign was_tx = (mode_ff == `PFD_MODE_TX);
  assign was_rx = (mode_ff == `PFD_MODE_RX);
  assign was_low = (mode_ff == `PFD_MODE_SLEEP) || (mode_ff == `PFD_MODE_STBY);

  // Other mode changes keep the contents
  assign mode_clear = (op_mode != mode_ff) &&
    ((was_low && in_rx) || (was_rx && in_tx) || was_tx);
  assign buf_clear = mode_clear || overflow_clr;
  assign empty_rise = fifo_none_left && !empty_d_ff;

  // Serializer byte moves; receive writes come only in receive mode, where host writes are shut out
  assign ser_wr = rx_collect_ff && lclk_rise && (bit_cnt_ff == `PFD_BIT_LSB) && in_rx;
  assign wr_req = (host_wr && active && !in_rx) || ser_wr;
  assign do_wr = wr_req && (count_ff != DEPTH) && !buf_clear;
  assign ser_rd = (state_ff == ST_LOAD) && (count_ff != `PFD_CNT_ZERO);
  assign do_rd = ((host_rd && active) || ser_rd) && (count_ff != `PFD_CNT_ZERO) && !buf_clear;

  always @*
  begin
    nxt_count = count_ff;
    if (do_wr && !do_rd)
      nxt_count = count_ff + `PFD_CNT_ONE;
    else if (do_rd && !do_wr)
      nxt_count = count_ff - `PFD_CNT_ONE;
  end

  // Storage has no reset; pointers and count alone say what is held
  always @(posedge clk_sys)
  begin
    if (do_wr)
      mem[wr_ptr_ff] <= ser_wr ? {ser_ff[`PFD_BYTE_W-2:0], rx_s} : host_wdata;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= {PTR_W{1'b0}};
      rd_ptr_ff <= {PTR_W{1'b0}};
      count_ff <= {CNT_W{1'b0}};
      mode_ff <= `PFD_MODE_SLEEP;
      cs_d_ff <= 1'b1;
      lclk_d_ff <= 1'b1;
      empty_d_ff <= 1'b1;
      host_rdata <= {`PFD_BYTE_W{1'b0}};
      fifo_none_left <= 1'b1;
      fifo_no_room <= 1'b0;
      fifo_overflow_flag <= 1'b0;
      fill_level_flag <= 1'b0;
      level_hold_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= op_mode;
      cs_d_ff <= cs_s;
      lclk_d_ff <= lclk_s;
      empty_d_ff <= fifo_none_left;
      if (buf_clear)
      begin
        wr_ptr_ff <= {PTR_W{1'b0}};
        rd_ptr_ff <= {PTR_W{1'b0}};
        count_ff <= {CNT_W{1'b0}};
        fifo_none_left <= 1'b1;
        fifo_no_room <= 1'b0;
        fill_level_flag <= 1'b0;
        level_hold_ff <= 1'b0;
      end
      else
      begin
        if (do_wr)
          wr_ptr_ff <= wr_ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        if (do_rd)
          rd_ptr_ff <= rd_ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        count_ff <= nxt_count;
        // Empty rises at once; it falls only while chip select is high or at its falling edge
        if (nxt_count == `PFD_CNT_ZERO)
          fifo_none_left <= 1'b1;
        else if (cs_s || cs_fall)
          fifo_none_left <= 1'b0;
        // Full follows the count left by this edge's transfer; level does too until full, then holds until the first transfer after empty
        fifo_no_room <= (nxt_count == DEPTH);
        if (nxt_count == `PFD_CNT_ZERO)
          level_hold_ff <= 1'b0;
        else if (nxt_count == DEPTH)
          level_hold_ff <= 1'b1;
        // Threshold edits alone do nothing until the next transfer
        if ((do_wr || do_rd) && !level_hold_ff && (nxt_count != DEPTH))
          fill_level_flag <= (nxt_count > {1'b0, fill_threshold});
      end
      // A serializer pop leaves the host's last byte in place
      if (do_rd && !ser_rd)
        host_rdata <= mem[rd_ptr_ff];
      // A new overflow wins over the host's clear
      if (wr_req && (count_ff == DEPTH))
        fifo_overflow_flag <= 1'b1;
      else if (overflow_clr)
        fifo_overflow_flag <= 1'b0;
    end
  end

  // Transmit serializer: loads from the buffer in ST_LOAD, shifts MSB first on link falling edges
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      ser_ff <= {`PFD_BYTE_W{1'b0}};
      bit_cnt_ff <= `PFD_BIT_MSB;
      byte_left_ff <= 3'h0;
      tx_bit <= 1'b0;
      frame_sent <= 1'b0;
      rx_collect_ff <= 1'b0;
    end
    else
    begin
      if (!in_tx)
        frame_sent <= 1'b0;
      rx_collect_ff <= in_rx && !continuous_mode;
      // Eight link rises make one received byte; the bit count wraps by itself
      if (in_rx && lclk_rise && rx_collect_ff)
      begin
        ser_ff <= {ser_ff[`PFD_BYTE_W-2:0], rx_s};
        bit_cnt_ff <= bit_cnt_ff - 3'h1;
      end
      else if (!in_rx && (state_ff == ST_IDLE))
        bit_cnt_ff <= `PFD_BIT_MSB;
      case (state_ff)
        ST_IDLE:
        begin
          // One frame per stay in transmit: frame_sent must drop first
          if (in_tx && !continuous_mode && !frame_sent && (count_ff != `PFD_CNT_ZERO))
          begin
            byte_left_ff <= frame_len_bytes;
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          if (!in_tx)
            state_ff <= ST_IDLE;
          // Waits here if the buffer runs dry in mid-frame
          else if (ser_rd && !buf_clear)
          begin
            ser_ff <= mem[rd_ptr_ff];
            bit_cnt_ff <= `PFD_BIT_MSB;
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (!in_tx)
            state_ff <= ST_IDLE;
          else if (lclk_fall)
          begin
            tx_bit <= ser_ff[`PFD_BYTE_W-1];
            ser_ff <= {ser_ff[`PFD_BYTE_W-2:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff - 3'h1;
            if (bit_cnt_ff == `PFD_BIT_LSB)
            begin
              if (byte_left_ff == 3'h0)
              begin
                frame_sent <= 1'b1;
                state_ff <= ST_IDLE;
              end
              else
              begin
                byte_left_ff <= byte_left_ff - 3'h1;
                state_ff <= ST_LOAD;
              end
            end
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  pfd_pattern_det u_det
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(pattern_detect_enable && in_rx),
    .pattern_length(pattern_length),
    .pattern_value(pattern_value),
    .bit_valid(lclk_rise && rx_collect_ff),
    .bit_in(rx_s),
    // Cleared as the buffer turns empty, so a pattern seen before any payload survives
    .clear((!in_rx && was_rx) || empty_rise),
    .pattern_match_flag(pattern_match_flag)
  );
endmodule // pfd_fifo_core

// ---- testbench/pfd_core_sva.sv ----
// Port-level checker for pfd_fifo_core.
// Assumes the mode codes of pfd_defs.vh; bound to every core instance.
`timescale 1ns/1ns
`include "pfd_defs.vh"
module pfd_core_sva
(
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Controls
  input wire [`PFD_MODE_W-1:0] op_mode,
  input wire continuous_mode,
  input wire mode_settled,
  input wire host_wr,
  input wire host_rd,
  input wire overflow_clr,
  input wire pattern_detect_enable,
  // Status
  input wire fifo_none_left,
  input wire fifo_no_room,
  input wire fifo_overflow_flag,
  input wire fill_level_flag,
  input wire frame_sent,
  input wire pattern_match_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  flags_excl_a:
    assert property (!(fifo_none_left && fifo_no_room)) else $error("empty and full together");
  ovf_set_a:
    assert property (host_wr && mode_settled && !continuous_mode && fifo_no_room
      && !overflow_clr && op_mode != `PFD_MODE_RX && $stable(op_mode)
      |=> fifo_overflow_flag && (fifo_no_room || op_mode == `PFD_MODE_TX))
    else $error("overflow not set on full write");
  ovf_clr_a:
    assert property (overflow_clr && !host_wr |=> fifo_none_left && !fifo_no_room
      && !fill_level_flag && !fifo_overflow_flag) else $error("overflow clear left data");
  lvl_hold_a:
    assert property (op_mode == `PFD_MODE_STBY && $past(op_mode, 2) == `PFD_MODE_STBY
      && !host_wr && !host_rd && !overflow_clr |=> $stable(fill_level_flag))
    else $error("level flag moved without access");
  mode_clr_a:
    assert property ((op_mode == `PFD_MODE_RX && ($past(op_mode) == `PFD_MODE_STBY
      || $past(op_mode) == `PFD_MODE_SLEEP)) || ($past(op_mode) == `PFD_MODE_TX
      && op_mode != `PFD_MODE_TX) |-> ##[0:2] fifo_none_left) else $error("mode change kept data");
  sent_hold_a:
    assert property (frame_sent && op_mode == `PFD_MODE_TX |=> frame_sent)
    else $error("frame sent dropped in transmit");
  match_en_a:
    assert property ($rose(pattern_match_flag) |-> $past(pattern_detect_enable)
      && $past(op_mode) == `PFD_MODE_RX) else $error("match while disabled");
  match_clr_a:
    assert property ($past(op_mode) == `PFD_MODE_RX && op_mode != `PFD_MODE_RX
      |-> ##[0:3] !pattern_match_flag) else $error("match kept after receive");
  cont_idle_a:
    assert property (continuous_mode && $past(continuous_mode) && op_mode == `PFD_MODE_STBY
      |=> $stable(fifo_none_left) && $stable(fifo_no_room)) else $error("buffer moved");
  cover property (host_wr && fifo_no_room);
  cover property ($rose(frame_sent));
  cover property ($rose(pattern_match_flag));
endmodule // pfd_core_sva
bind pfd_fifo_core pfd_core_sva chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .op_mode(op_mode),
  .continuous_mode(continuous_mode), .mode_settled(mode_settled), .host_wr(host_wr),
  .host_rd(host_rd),
  .overflow_clr(overflow_clr), .pattern_detect_enable(pattern_detect_enable),
  .fifo_none_left(fifo_none_left), .fifo_no_room(fifo_no_room),
  .fifo_overflow_flag(fifo_overflow_flag), .fill_level_flag(fill_level_flag),
  .frame_sent(frame_sent), .pattern_match_flag(pattern_match_flag));

// ---- testbench/pfd_modem_model.sv ----
// Modem-side model: clocks the link, drives received bits, samples sent bits.
// Assumes rx_bit is sampled on link_clk rise and tx_bit moves after a fall.
`timescale 1ns/1ns
module pfd_modem_model
(
  // Link
  output reg link_clk,
  output reg rx_bit,
  input wire tx_bit,
  // Last eight sent bits
  output reg [7:0] cap
);
  initial
  begin
    link_clk = 1'b1;
    rx_bit = 1'b0;
    cap = 8'h00;
  end
  // Clock idles high between frames, so every bit opens with a fall
  task xfer(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        link_clk = 1'b0;
        rx_bit = b[i];
        #80 link_clk = 1'b1;
        #80 cap = {cap[6:0], tx_bit};
      end
      // A released line must not keep showing its last level
      rx_bit = ~rx_bit;
    end
  endtask
endmodule // pfd_modem_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for pfd_fifo_core with the modem-side model.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ns
`include "pfd_defs.vh"
module tb_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [`PFD_MODE_W-1:0] op_mode = `PFD_MODE_STBY;
  reg continuous_mode = 1'b0;
  reg spi_cs_n = 1'b1;
  reg host_wr = 1'b0;
  reg host_rd = 1'b0;
  reg overflow_clr = 1'b0;
  reg pattern_detect_enable = 1'b0;
  reg mode_settled = 1'b1;
  reg [2:0] frame_len_bytes = 3'h0;
  reg [2:0] pattern_length = 3'h0;
  reg [7:0] host_wdata = 8'h00;
  reg [5:0] fill_threshold = 6'h0a;
  wire [7:0] host_rdata;
  wire [7:0] cap;
  wire link_clk, rx_bit, tx_bit, fifo_none_left, fifo_no_room, fifo_overflow_flag;
  wire fill_level_flag, frame_sent, pattern_match_flag;
  integer error_cnt = 0;
  integer n_tests = 0;
  integer i;
  always #10 clk_sys = ~clk_sys;
  pfd_fifo_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .op_mode(op_mode),
    .continuous_mode(continuous_mode), .mode_settled(mode_settled),
    .frame_len_bytes(frame_len_bytes),
    .spi_cs_n(spi_cs_n), .host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd),
    .host_rdata(host_rdata), .overflow_clr(overflow_clr), .fill_threshold(fill_threshold),
    .pattern_detect_enable(pattern_detect_enable), .pattern_length(pattern_length),
    .pattern_value(64'h5a11223344556677),
    .link_clk(link_clk), .rx_bit(rx_bit), .tx_bit(tx_bit), .fifo_none_left(fifo_none_left),
    .fifo_no_room(fifo_no_room), .fifo_overflow_flag(fifo_overflow_flag),
    .fill_level_flag(fill_level_flag), .frame_sent(frame_sent),
    .pattern_match_flag(pattern_match_flag));
  pfd_modem_model lnk_u (.link_clk(link_clk), .rx_bit(rx_bit), .tx_bit(tx_bit), .cap(cap));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [8*6-1:0] name, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s exp %h got %h", name, e, g);
      end
    end
  endtask
  // Order: empty, full, overflow
  task flags(input [2:0] e);
    begin
      @(negedge clk_sys);
      chk("flags", {5'h00, e}, {5'h00, fifo_none_left, fifo_no_room, fifo_overflow_flag});
    end
  endtask
  task wr(input [7:0] d);
    begin
      @(negedge clk_sys);
      host_wr = 1'b1;
      host_wdata = d;
      @(negedge clk_sys);
      host_wr = 1'b0;
    end
  endtask
  // Chip select frames each read, as the host does
  task rd(input [7:0] e);
    begin
      @(negedge clk_sys);
      spi_cs_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      host_rd = 1'b1;
      @(negedge clk_sys);
      host_rd = 1'b0;
      chk("rdata", e, host_rdata);
      spi_cs_n = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
  endtask
  task mode(input [2:0] m);
    begin
      @(negedge clk_sys);
      op_mode = m;
      repeat (5) @(negedge clk_sys);
    end
  endtask
  task clr;
    begin
      @(negedge clk_sys);
      overflow_clr = 1'b1;
      @(negedge clk_sys);
      overflow_clr = 1'b0;
    end
  endtask
  task wait_sent;
    begin
      for (i = 0; i < 50 && frame_sent !== 1'b1; i = i + 1)
        @(negedge clk_sys);
    end
  endtask
  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    flags(3'b100);
    for (i = 0; i < 65; i = i + 1)
    begin
      wr(i + 1);
      if (i == 9)
        chk("level", 8'h00, {7'h00, fill_level_flag});
      if (i == 10)
      begin
        chk("level", 8'h01, {7'h00, fill_level_flag});
        fill_threshold = 6'h3f;
        repeat (3) @(negedge clk_sys);
        chk("level", 8'h01, {7'h00, fill_level_flag});
      end
      if (i == 11)
        chk("level", 8'h00, {7'h00, fill_level_flag});
    end
    flags(3'b011);
    for (i = 0; i < 64; i = i + 1)
    begin
      rd(i + 1);
      chk("empty", {7'h00, i == 63}, {7'h00, fifo_none_left});
    end
    wr(8'h77);
    clr;
    flags(3'b100);
    mode_settled = 1'b0;
    wr(8'h22);
    flags(3'b100);
    mode_settled = 1'b1;
    continuous_mode = 1'b1;
    wr(8'h11);
    flags(3'b100);
    continuous_mode = 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      mode(i % 2 ? `PFD_MODE_SLEEP : `PFD_MODE_STBY);
      wr(8'h33);
      mode(i == 0 ? `PFD_MODE_SLEEP : i == 1 ? `PFD_MODE_STBY : `PFD_MODE_RX);
      chk("empty", {7'h00, i > 1}, {7'h00, fifo_none_left});
      clr;
      mode(`PFD_MODE_STBY);
    end
    wr(8'ha5);
    wr(8'h3c);
    wr(8'h96);
    frame_len_bytes = 3'h1;
    mode(`PFD_MODE_TX);
    lnk_u.xfer(8'h00);
    chk("txbyte", 8'ha5, cap);
    chk("sent", 8'h00, {7'h00, frame_sent});
    lnk_u.xfer(8'h00);
    chk("txbyte", 8'h3c, cap);
    wait_sent;
    chk("sent", 8'h01, {7'h00, frame_sent});
    if (frame_sent !== 1'b1)
      summarize;
    chk("empty", 8'h00, {7'h00, fifo_none_left});
    mode(`PFD_MODE_STBY);
    chk("empty", 8'h01, {7'h00, fifo_none_left});
    mode(`PFD_MODE_RX);
    lnk_u.xfer(8'h5a);
    repeat (5) @(negedge clk_sys);
    chk("match", 8'h00, {7'h00, pattern_match_flag});
    chk("empty", 8'h00, {7'h00, fifo_none_left});
    pattern_detect_enable = 1'b1;
    pattern_length = 3'h1;
    lnk_u.xfer(8'h5a);
    repeat (5) @(negedge clk_sys);
    chk("match", 8'h00, {7'h00, pattern_match_flag});
    lnk_u.xfer(8'h11);
    repeat (5) @(negedge clk_sys);
    chk("match", 8'h01, {7'h00, pattern_match_flag});
    mode(`PFD_MODE_STBY);
    chk("match", 8'h00, {7'h00, pattern_match_flag});
    rd(8'h5a);
    rd(8'h5a);
    rd(8'h11);
    flags(3'b100);
    summarize;
  end
endmodule // tb_top
